// ==== verilog/nvsc_regs.svh ====
// Timing counts and sequence addresses for the shadow-store host controller.
// Assumes a 10 MHz mclk; included by bare name from the design and the device model.
`ifndef NVSC_REGS_SVH
`define NVSC_REGS_SVH
`define NVSC_CLK_MHZ 10
`define NVSC_PUR_US 550
`define NVSC_STORE_MS 10
`define NVSC_STB_CYC 3
`define NVSC_SEQ0 14'h0E38
`define NVSC_SEQ1 14'h31C7
`define NVSC_SEQ2 14'h03E0
`define NVSC_SEQ3 14'h3C1F
`define NVSC_SEQ4 14'h303F
`define NVSC_SEQ_COMMIT 14'h0FC0
`define NVSC_SEQ_RESTORE 14'h0C63
`define NVSC_SEQ_LAST 3'h5
`endif

// ==== verilog/nvsc_pkg.sv ====
// Types shared by the shadow-store host controller.
// Assumes nothing beyond the constant header.
package nvsc_pkg;
	typedef enum logic [1:0] {
		OP_READ = 2'h0,
		OP_WRITE = 2'h1,
		OP_COMMIT = 2'h2,
		OP_RESTORE = 2'h3
	} nvsc_op_t;
	typedef enum logic [2:0] {
		ST_POWER = 3'h0,
		ST_PUR = 3'h1,
		ST_IDLE = 3'h2,
		ST_SETUP = 3'h3,
		ST_STROBE = 3'h4,
		ST_RECOV = 3'h5,
		ST_NVWAIT = 3'h6
	} nvsc_state_t;
	typedef struct packed {
		logic [14:0] addr;
		logic ce_n;
		logic we_n;
		logic oe_n;
		logic [7:0] dq_out;
		logic dq_oe_n;
	} nvsc_pins_t;
endpackage : nvsc_pkg

// ==== verilog/nvsc_host.sv ====
// Host controller driving the asynchronous pins of a shadow-store SRAM.
// Assumes the supply comparator and the data pins are asynchronous to mclk.
// Notes on behaviour
// - Host must not be writing when the power-up restore finishes.
// - Five leading reads then 0x0FC0 start a commit.
// - Same five leading reads then 0x0C63 start a restore.
// - Only the exact consecutive order of six addresses triggers.
// - Host keeps write strobe high through all six sequence cycles.
`timescale 1ns/1ps
`include "nvsc_regs.svh"
module nvsc_host
	import nvsc_pkg::*;
#(
	parameter int PUR_CYC = `NVSC_PUR_US * `NVSC_CLK_MHZ,
	parameter int STORE_CYC = `NVSC_STORE_MS * 1000 * `NVSC_CLK_MHZ,
	parameter int RCL_CYC = `NVSC_PUR_US * `NVSC_CLK_MHZ
)
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic pwr_ok,
	input wire logic cmd_valid,
	input wire nvsc_op_t cmd_op,
	input wire logic [14:0] cmd_addr,
	input wire logic [7:0] cmd_wdata,
	output logic cmd_ready,
	output logic rd_valid,
	output logic [7:0] rd_data,
	output logic busy,
	input wire logic [7:0] dq_in,
	output nvsc_pins_t sram
);

	localparam logic [16:0] STB_M1 = 17'(`NVSC_STB_CYC - 1);

	logic pwr_m_q;
	logic pwr_s_q;
	logic [7:0] dq_m_q;
	logic [7:0] dq_s_q;
	nvsc_state_t st_q;
	nvsc_state_t st_d;
	logic [16:0] tmr_q;
	logic [16:0] tmr_d;
	logic [2:0] step_q;
	logic [2:0] step_d;
	nvsc_op_t op_q;
	nvsc_op_t op_d;
	logic [7:0] wdata_q;
	logic [7:0] wdata_d;
	nvsc_pins_t sram_q;
	nvsc_pins_t sram_d;
	logic ready_q;
	logic ready_d;
	logic rdv_q;
	logic rdv_d;
	logic [7:0] rdat_q;
	logic [7:0] rdat_d;
	logic busy_q;
	logic busy_d;
	logic is_seq;

	// Sequence addresses; the top address bit is driven low, the device
	// ignores it during matching.
	function automatic logic [14:0] seq_addr(input logic [2:0] step,
		input nvsc_op_t op);
		logic [13:0] a;
		a = `NVSC_SEQ0;
		case (step)
			3'h0: a = `NVSC_SEQ0;
			3'h1: a = `NVSC_SEQ1;
			3'h2: a = `NVSC_SEQ2;
			3'h3: a = `NVSC_SEQ3;
			3'h4: a = `NVSC_SEQ4;
			default: a = (op == OP_COMMIT) ? `NVSC_SEQ_COMMIT :
				`NVSC_SEQ_RESTORE;
		endcase
		return {1'b0, a};
	endfunction : seq_addr

	// The comparator and the data bus both settle asynchronously to mclk.
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			pwr_m_q <= 1'b0;
			pwr_s_q <= 1'b0;
			dq_m_q <= 8'h00;
			dq_s_q <= 8'h00;
		end
		else
		begin
			pwr_m_q <= pwr_ok;
			pwr_s_q <= pwr_m_q;
			dq_m_q <= dq_in;
			dq_s_q <= dq_m_q;
		end
	end

	assign is_seq = (op_q == OP_COMMIT) || (op_q == OP_RESTORE);

	always_comb
	begin
		st_d = st_q;
		tmr_d = tmr_q;
		step_d = step_q;
		op_d = op_q;
		wdata_d = wdata_q;
		sram_d = sram_q;
		rdv_d = 1'b0;
		rdat_d = rdat_q;
		if (!pwr_s_q)
		begin
			// Low supply: the device drops writes and commits and latches a
			// restore, so the host parks every strobe and forgets any sequence.
			st_d = ST_POWER;
			step_d = 3'h0;
			sram_d.ce_n = 1'b1;
			sram_d.we_n = 1'b1;
			sram_d.oe_n = 1'b1;
			sram_d.dq_oe_n = 1'b1;
		end
		else
		begin
			case (st_q)
				ST_POWER:
				begin
					st_d = ST_PUR;
					tmr_d = 17'(PUR_CYC - 1);
				end
				ST_PUR:
				begin
					// No access at all until the restore is surely done, so
					// no write can be active when it finishes.
					if (tmr_q == 17'h00000)
						st_d = ST_IDLE;
					else
						tmr_d = tmr_q - 17'h00001;
				end
				ST_IDLE:
				begin
					sram_d.dq_oe_n = 1'b1;
					if (cmd_valid && ready_q)
					begin
						op_d = cmd_op;
						wdata_d = cmd_wdata;
						step_d = 3'h0;
						if ((cmd_op == OP_COMMIT) || (cmd_op == OP_RESTORE))
							sram_d.addr = seq_addr(3'h0, cmd_op);
						else
							sram_d.addr = cmd_addr;
						st_d = ST_SETUP;
					end
				end
				ST_SETUP:
				begin
					sram_d.ce_n = 1'b0;
					// Sequence cycles are chip-select reads with WE held high.
					if (op_q == OP_WRITE)
					begin
						sram_d.we_n = 1'b0;
						sram_d.dq_out = wdata_q;
						sram_d.dq_oe_n = 1'b0;
					end
					else
						sram_d.oe_n = 1'b0;
					tmr_d = STB_M1;
					st_d = ST_STROBE;
				end
				ST_STROBE:
				begin
					if (tmr_q == 17'h00000)
					begin
						sram_d.ce_n = 1'b1;
						sram_d.we_n = 1'b1;
						sram_d.oe_n = 1'b1;
						rdat_d = dq_s_q;
						rdv_d = (op_q == OP_READ);
						st_d = ST_RECOV;
					end
					else
						tmr_d = tmr_q - 17'h00001;
				end
				ST_RECOV:
				begin
					// Data is held one cycle past the rising strobes.
					sram_d.dq_oe_n = 1'b1;
					if (is_seq && (step_q != `NVSC_SEQ_LAST))
					begin
						// Next sequence access follows with no user access
						// allowed in between.
						step_d = step_q + 3'h1;
						sram_d.addr = seq_addr(step_q + 3'h1, op_q);
						st_d = ST_SETUP;
					end
					else if (is_seq)
					begin
						// The device erases and programs, or clears and
						// reloads, with its pins dead for the whole time.
						tmr_d = (op_q == OP_COMMIT) ? 17'(STORE_CYC - 1) :
							17'(RCL_CYC - 1);
						st_d = ST_NVWAIT;
					end
					else
						st_d = ST_IDLE;
				end
				ST_NVWAIT:
				begin
					if (tmr_q == 17'h00000)
					begin
						step_d = 3'h0;
						st_d = ST_IDLE;
					end
					else
						tmr_d = tmr_q - 17'h00001;
				end
				default:
					st_d = ST_POWER;
			endcase
		end
		ready_d = (st_d == ST_IDLE) && !(cmd_valid && ready_q);
		busy_d = (st_d != ST_IDLE) || (cmd_valid && ready_q);
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			st_q <= ST_POWER;
			tmr_q <= 17'h00000;
			step_q <= 3'h0;
			op_q <= OP_READ;
			wdata_q <= 8'h00;
			sram_q <= '{addr: 15'h0000, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
				dq_out: 8'h00, dq_oe_n: 1'b1};
			ready_q <= 1'b0;
			rdv_q <= 1'b0;
			rdat_q <= 8'h00;
			busy_q <= 1'b1;
		end
		else
		begin
			st_q <= st_d;
			tmr_q <= tmr_d;
			step_q <= step_d;
			op_q <= op_d;
			wdata_q <= wdata_d;
			sram_q <= sram_d;
			ready_q <= ready_d;
			rdv_q <= rdv_d;
			rdat_q <= rdat_d;
			busy_q <= busy_d;
		end
	end

	assign cmd_ready = ready_q;
	assign rd_valid = rdv_q;
	assign rd_data = rdat_q;
	assign busy = busy_q;
	assign sram = sram_q;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	sequence s_last_access;
		(st_q == ST_RECOV) && is_seq && (step_q == `NVSC_SEQ_LAST);
	endsequence
	sequence s_dead_pins;
		(sram_q.ce_n && sram_q.we_n)[*8];
	endsequence

	a_no_write_low: assert property (!sram_q.we_n |-> $past(pwr_s_q))
		else $error("write strobe asserted while supply low");
	a_pur_quiet: assert property ($rose(pwr_s_q) |=> s_dead_pins)
		else $error("access during power-up restore wait");
	a_pur_no_we: assert property (st_q == ST_PUR |-> sram_q.we_n)
		else $error("write active during power-up restore");
	a_seq_we_high: assert property (is_seq && st_q == ST_STROBE
		|-> sram_q.we_n && !sram_q.ce_n)
		else $error("sequence cycle not a chip-select read");
	a_seq_msb_low: assert property (is_seq && !sram_q.ce_n
		|-> !sram_q.addr[14])
		else $error("sequence address top bit not low");
	a_seq_order: assert property ($changed(step_q) |->
		step_q == $past(step_q) + 3'h1 || step_q == 3'h0)
		else $error("sequence step skipped");
	a_seq_no_gap: assert property (is_seq && st_q != ST_IDLE
		&& st_q != ST_NVWAIT |-> !cmd_ready)
		else $error("user access could break sequence");
	a_commit_last: assert property ((s_last_access and op_q == OP_COMMIT)
		|-> sram_q.addr[13:0] == `NVSC_SEQ_COMMIT)
		else $error("commit sequence ended on wrong address");
	a_restore_last: assert property ((s_last_access and op_q == OP_RESTORE)
		|-> sram_q.addr[13:0] == `NVSC_SEQ_RESTORE)
		else $error("restore sequence ended on wrong address");
	a_commit_hold: assert property ((s_last_access and op_q == OP_COMMIT)
		|=> s_dead_pins)
		else $error("pins active during commit");

endmodule : nvsc_host

// ==== dv/nvsc_dev_model.sv ====
// Behavioural shadow-store SRAM as seen from its asynchronous pins.
// Assumes the bench resolves DQ and drives vcc_ok as power-good.
`timescale 1ns/1ps
`include "nvsc_regs.svh"
module nvsc_dev_model #(
	parameter int STORE_NS = 1800,
	parameter int RECALL_NS = 1200
)
(
	input wire logic [14:0] addr,
	input wire logic ce_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic [7:0] dq_host,
	input wire logic vcc_ok,
	output logic [7:0] dq
);
	logic [7:0] mem [0:32767];
	logic [7:0] nv [0:32767];
	logic [13:0] seq [0:4];
	logic [7:0] last;
	logic dead;
	logic pend;
	logic wr_seen;
	int step;
	initial
	begin
		seq = '{`NVSC_SEQ0, `NVSC_SEQ1, `NVSC_SEQ2, `NVSC_SEQ3, `NVSC_SEQ4};
		foreach (nv[i])
			nv[i] = 8'h00;
		dead = 1'b1;
		pend = 1'b1;
		step = 0;
		last = 8'h00;
		wr_seen = 1'b0;
	end
	task automatic recall();
		dead = 1'b1;
		foreach (mem[i])
			mem[i] = 8'h00;
		foreach (mem[i])
			mem[i] = nv[i];
		#(RECALL_NS);
		dead = 1'b0;
	endtask : recall
	// A released bus shows the inverse of its last value, never a hold.
	assign dq = (!ce_n && !oe_n && we_n && !dead) ? mem[addr] : ~last;
	always @(negedge vcc_ok)
		pend = 1'b1;
	always @(posedge vcc_ok)
		if (pend)
		begin
			pend = 1'b0;
			recall();
		end
	always @(negedge ce_n)
		wr_seen = !we_n;
	always @(negedge we_n)
		if (!ce_n)
			wr_seen = 1'b1;
	always @(posedge ce_n)
		if (!dead)
		begin
			if (wr_seen)
			begin
				if (vcc_ok)
					mem[addr] = dq_host;
				step = 0;
			end
			else if (step == 5 && addr[13:0] == `NVSC_SEQ_COMMIT && vcc_ok)
			begin
				step = 0;
				dead = 1'b1;
				foreach (nv[i])
					nv[i] = 8'hFF;
				foreach (nv[i])
					nv[i] = mem[i];
				#(STORE_NS);
				dead = 1'b0;
			end
			else if (step == 5 && addr[13:0] == `NVSC_SEQ_RESTORE)
			begin
				step = 0;
				recall();
			end
			else if (step < 5 && addr[13:0] == seq[step])
			begin
				last = mem[addr];
				step++;
			end
			else
			begin
				last = mem[addr];
				step = (addr[13:0] == seq[0]) ? 1 : 0;
			end
		end
endmodule : nvsc_dev_model

// ==== dv/tb.sv ====
// Self-checking bench for the shadow-store host controller.
// Assumes the device model file and the design package are compiled first.
`timescale 1ns/1ps
module tb import nvsc_pkg::*;;
	logic mclk;
	logic rst_n;
	logic pwr_ok;
	logic cmd_valid;
	logic cmd_ready;
	logic rd_valid;
	logic busy;
	nvsc_op_t cmd_op;
	logic [14:0] cmd_addr;
	logic [7:0] cmd_wdata;
	logic [7:0] rd_data;
	logic [7:0] dq_in;
	logic [7:0] dev_dq;
	nvsc_pins_t sram;
	int fails;
	int n_compared;
	nvsc_host #(.PUR_CYC(16), .STORE_CYC(20), .RCL_CYC(16)) dut (
		.mclk(mclk), .rst_n(rst_n), .pwr_ok(pwr_ok), .cmd_valid(cmd_valid),
		.cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
		.cmd_ready(cmd_ready), .rd_valid(rd_valid), .rd_data(rd_data),
		.busy(busy), .dq_in(dq_in), .sram(sram));
	nvsc_dev_model dev (.addr(sram.addr), .ce_n(sram.ce_n),
		.we_n(sram.we_n), .oe_n(sram.oe_n), .dq_host(sram.dq_out),
		.vcc_ok(pwr_ok), .dq(dev_dq));
	assign dq_in = !sram.dq_oe_n ? sram.dq_out : dev_dq;
	task end_sim();
		$display("compared %0d wrong %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task op(input nvsc_op_t o, input logic [14:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(negedge mclk);
		cmd_valid = 1'b1;
		cmd_op = o;
		cmd_addr = a;
		cmd_wdata = d;
		// Ready is looked at mid-cycle; the following rising edge takes it.
		while (cmd_ready !== 1'b1 && n < 200)
		begin
			@(negedge mclk);
			n++;
		end
		chk({7'h00, cmd_ready}, 8'h01);
		@(posedge mclk);
		@(negedge mclk);
		cmd_valid = 1'b0;
	endtask : op
	task rd(input logic [14:0] a, input logic [7:0] exp);
		int n;
		n = 0;
		op(OP_READ, a, 8'h00);
		while (rd_valid !== 1'b1 && n < 20)
		begin
			@(negedge mclk);
			n++;
		end
		chk({7'h00, rd_valid}, 8'h01);
		chk(rd_data, exp);
	endtask : rd
	task t_rw();
		op(OP_WRITE, 15'h0123, 8'hA5);
		op(OP_WRITE, 15'h4123, 8'h3C);
		rd(15'h0123, 8'hA5);
		rd(15'h4123, 8'h3C);
	endtask : t_rw
	task t_nv();
		op(OP_WRITE, 15'h0010, 8'h5A);
		op(OP_COMMIT, 15'h0000, 8'h00);
		op(OP_WRITE, 15'h0010, 8'h11);
		rd(15'h0010, 8'h11);
		op(OP_RESTORE, 15'h0000, 8'h00);
		rd(15'h0010, 8'h5A);
	endtask : t_nv
	task t_power();
		op(OP_WRITE, 15'h0020, 8'h77);
		@(negedge mclk);
		pwr_ok = 1'b0;
		repeat (4) @(negedge mclk);
		cmd_valid = 1'b1;
		cmd_op = OP_WRITE;
		repeat (30) @(negedge mclk);
		chk({7'h00, cmd_ready}, 8'h00);
		cmd_valid = 1'b0;
		pwr_ok = 1'b1;
		rd(15'h0020, 8'h00);
		rd(15'h0010, 8'h5A);
	endtask : t_power
	initial
	begin
		mclk = 1'b0;
		forever
			#50 mclk = ~mclk;
	end
	initial
	begin
		#2000000;
		fails++;
		end_sim();
	end
	initial
	begin
		fails = 0;
		n_compared = 0;
		rst_n = 1'b0;
		pwr_ok = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = OP_READ;
		cmd_addr = 15'h0000;
		cmd_wdata = 8'h00;
		repeat (8) @(negedge mclk);
		rst_n = 1'b1;
		pwr_ok = 1'b1;
		t_rw();
		t_nv();
		t_power();
		end_sim();
	end
endmodule : tb
